/* File: include/gtc_pkg.sv */
// Purpose: shared constants for the gated timer and capture/compare unit
// Assumes: 8-bit registers, one aligned 32-bit word each on AXI4-Lite
// Notes:   offsets are byte addresses
package gtc_pkg;
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  A_TIMER_CTRL   = 8'h00;
   localparam logic [7:0]  A_GATE_CTRL    = 8'h04;
   localparam logic [7:0]  A_CC_MODE      = 8'h08;
   localparam logic [7:0]  A_CC_LOW       = 8'h0C;
   localparam logic [7:0]  A_CC_HIGH      = 8'h10;
   localparam logic [7:0]  A_COUNT_LOW    = 8'h14;
   localparam logic [7:0]  A_COUNT_HIGH   = 8'h18;
   localparam logic [7:0]  A_IRQ_EN       = 8'h1C;
   localparam logic [7:0]  A_FLAGS        = 8'h20;
   // field positions
   localparam int          TIMER_ON_POS   = 0;
   localparam int          GATE_EN_POS    = 7;
   localparam int          GATE_POL_POS   = 6;
   localparam int          GATE_TOG_POS   = 5;
   localparam int          GATE_VAL_POS   = 2;
   localparam int          CC_FLAG_POS    = 2;
   localparam logic [7:0]  GATE_WR_MASK   = 8'hFB;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   // gate sources
   localparam logic [1:0]  SRC_PIN        = 2'h0;
   localparam logic [1:0]  SRC_T0_OVF     = 2'h1;
   localparam logic [1:0]  SRC_T2_MATCH   = 2'h2;
   localparam logic [1:0]  SRC_WDT        = 2'h3;
   // mode codes
   localparam logic [3:0]  M_OFF          = 4'h0;
   localparam logic [3:0]  M_RSV1         = 4'h1;
   localparam logic [3:0]  M_CMP_TOGGLE   = 4'h2;
   localparam logic [3:0]  M_RSV3         = 4'h3;
   localparam logic [3:0]  M_CAP_FALL     = 4'h4;
   localparam logic [3:0]  M_CAP_RISE     = 4'h5;
   localparam logic [3:0]  M_CAP_RISE4    = 4'h6;
   localparam logic [3:0]  M_CAP_RISE16   = 4'h7;
   localparam logic [3:0]  M_CMP_SET      = 4'h8;
   localparam logic [3:0]  M_CMP_CLR      = 4'h9;
   localparam logic [3:0]  M_CMP_SOFT     = 4'hA;
   localparam logic [3:0]  M_CMP_SPECIAL  = 4'hB;
   localparam logic [3:0]  CAP_DIV4_LAST  = 4'h3;
   localparam logic [3:0]  CAP_DIV16_LAST = 4'hF;
   // watchdog base interval in system clocks, scaled by the prescaler only when it is assigned to the watchdog
   localparam logic [15:0] WDT_BASE_CYCLES = 16'h0010;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   function automatic logic is_capture(input logic [3:0] m);
      return m[3:2] == 2'h1;
   endfunction

   function automatic logic is_compare(input logic [3:0] m);
      return (m == M_CMP_TOGGLE) || (m[3:2] == 2'h2);
   endfunction
endpackage

/* File: verilog/cc_capture_edge.sv */
// Purpose: capture event detector with edge select and 1/4/16 prescale
// Assumes: pin already synchronous to clk
// Notes:   prescale count restarts whenever the mode changes
`timescale 1ns/1ps
`default_nettype none
module cc_capture_edge import gtc_pkg::*; (
   input  wire logic       clk,      // system clock
   input  wire logic       srst,     // sync reset
   input  wire logic [3:0] mode,     // capture/compare mode
   input  wire logic       pin,      // capture input pin
   output logic            evt       // one-cycle capture event
);
   logic       pin_prev_r;
   logic [3:0] div_r;
   logic [3:0] mode_prev_r;
   logic       rise;
   logic       fall;
   logic [3:0] last;

   assign rise = pin & ~pin_prev_r;
   assign fall = ~pin & pin_prev_r;
   assign last = (mode == M_CAP_RISE16) ? CAP_DIV16_LAST :
                 (mode == M_CAP_RISE4)  ? CAP_DIV4_LAST  : 4'h0;

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_prev_r  <= 1'b0;
         mode_prev_r <= M_OFF;
      end else begin
         pin_prev_r  <= pin;
         mode_prev_r <= mode;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !is_capture(mode) || mode != mode_prev_r) begin
         div_r <= 4'h0;
      end else if (rise) begin
         div_r <= (div_r == last) ? 4'h0 : div_r + 4'h1;
      end
   end

   always_comb begin
      evt = 1'b0;
      if (mode == mode_prev_r) begin
         if (mode == M_CAP_FALL) evt = fall;
         else if (is_capture(mode)) evt = rise && (div_r == last);
      end
   end
endmodule
`default_nettype wire

/* File: verilog/wdt_gate_counter.sv */
// Purpose: watchdog interval counter used as a gate source
// Assumes: clear is a one-cycle pulse from any watchdog-clearing operation
// Notes:   prescaler changes mid-interval shorten or stretch that interval
`timescale 1ns/1ps
`default_nettype none
module wdt_gate_counter import gtc_pkg::*; (
   input  wire logic       clk,      // system clock
   input  wire logic       srst,     // sync reset
   input  wire logic       run,      // oscillator and counter on
   input  wire logic       clear,    // restart interval
   input  wire logic       prescaler_assign,      // prescaler assigned to watchdog
   input  wire logic [2:0] rate,     // prescaler rate
   output logic            ovf       // one-cycle overflow pulse
);
   logic [15:0] cnt_r;
   logic [15:0] period;

   assign period = prescaler_assign ? (WDT_BASE_CYCLES << rate) : WDT_BASE_CYCLES;

   always_ff @(posedge clk) begin
      if (srst || clear || !run) begin
         cnt_r <= 16'h0000;
         ovf   <= 1'b0;
      end else if (cnt_r >= period - 16'h0001) begin
         cnt_r <= 16'h0000;
         ovf   <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         ovf   <= 1'b0;
      end
   end

   a_clear_restart: assert property (@(posedge clk) disable iff (srst)
      clear |=> (cnt_r == 16'h0000) && !ovf) else $error("clear did not restart");
endmodule
`default_nettype wire

/* File: verilog/timer_gate_ccp.sv */
// Purpose: gated 16-bit timer with capture/compare mode unit, AXI4-Lite regs
// Assumes: TIMER_TICK is a one-cycle pulse per rising edge of the timer clock
// Notes:   PWM waveform is not generated here; duty bits are only stored
// Operation
// - count freely unless gate enable set
// - gate active increments, inactive holds count
// - polarity bit selects low or high active
// - two-bit field picks one of four sources
// - timer0 rollover makes a gate pulse
// - timer2 period clear makes a gate pulse
// - gate on watchdog source powers watchdog
// - prescaler settings still set watchdog interval
// - watchdog reset/wake only with enable config
// - any watchdog clear restarts gate interval
// - mode zero turns unit off, resets it
// - reserved modes select nothing
// - capture on fall, rise, 4th, 16th
// - toggle mode flips output, sets flag
// - set or clear output on match, flag
// - soft mode only sets the flag
// - special mode flags, clears timer, starts conversion
// - PWM codes; duty low bits stored
// - mode register top bits read zero
// - timer is a 16-bit byte pair
`timescale 1ns/1ps
`default_nettype none
module timer_gate_ccp import gtc_pkg::*; (
   input  wire logic              CLK_SYS,       // 25 MHz system clock
   input  wire logic              SRST,          // sync reset, active high
   input  wire logic [ADDR_W-1:0] AWADDR,        // write address
   input  wire logic              AWVALID,       // write address valid
   output logic                   AWREADY,       // write address ready
   input  wire logic [31:0]       WDATA,         // write data
   input  wire logic [3:0]        WSTRB,         // write strobes
   input  wire logic              WVALID,        // write data valid
   output logic                   WREADY,        // write data ready
   output logic [1:0]             BRESP,         // write response
   output logic                   BVALID,        // write response valid
   input  wire logic              BREADY,        // write response ready
   input  wire logic [ADDR_W-1:0] ARADDR,        // read address
   input  wire logic              ARVALID,       // read address valid
   output logic                   ARREADY,       // read address ready
   output logic [31:0]            RDATA,         // read data
   output logic [1:0]             RRESP,         // read response
   output logic                   RVALID,        // read data valid
   input  wire logic              RREADY,        // read data ready
   input  wire logic              TIMER_TICK,    // timer clock rising edge
   input  wire logic              GATE_INPUT,    // external gate pin
   input  wire logic [7:0]        TIMER0_COUNT,  // 8-bit timer0 count
   input  wire logic [7:0]        TIMER2_COUNT,  // timer2 count
   input  wire logic [7:0]        TIMER2_PERIOD, // timer2 period value
   input  wire logic              PRESCALER_ASSIGN, // prescaler on watchdog
   input  wire logic [2:0]        PRESCALER_RATE,   // prescaler rate
   input  wire logic              WATCHDOG_ENABLE_CONFIG, // watchdog enable
   input  wire logic              WATCHDOG_CLEAR,  // clear, sleep or wake pulse
   input  wire logic              SLEEP_ACTIVE,    // device asleep
   input  wire logic              CC_INPUT_PIN,    // capture input
   input  wire logic              ADC_ENABLE,      // converter enabled
   output logic                   CC_OUTPUT_PIN,   // compare output
   output logic                   ADC_START,       // conversion start pulse
   output logic                   WDT_OSC_ON,      // watchdog running
   output logic                   WDT_RESET_REQ,   // watchdog reset pulse
   output logic                   WDT_WAKE_REQ     // watchdog wake pulse
);
   logic [7:0]  ctrl_r;
   logic [7:0]  gcon_r;
   logic [5:0]  mode_r;
   logic [15:0] ccval_r;
   logic [15:0] count_r;
   logic [7:0]  irqen_r;
   logic [7:0]  flags_r;
   logic        aw_full_r;
   logic        w_full_r;
   logic [7:0]  aw_addr_r;
   logic [7:0]  w_data_r;
   logic        w_lane0_r;
   logic        t0_prev_valid_r;
   logic [7:0]  t0_prev_r;
   logic [7:0]  t2_prev_r;
   logic        t0_ovf_r;
   logic        t2_match_r;
   logic        src_prev_r;
   logic        toggle_r;
   logic        match_prev_r;
   logic        wdt_ovf;
   logic        cap_evt;
   logic        wr_do;
   logic        wr_en;
   logic        gate_en;
   logic        gate_pol;
   logic        gate_tog;
   logic [1:0]  gate_src;
   logic        src_raw;
   logic        src_lvl;
   logic        gate_active;
   logic        inc_en;
   logic        cnt_wr;
   logic        cmp_hit;
   logic        cap_hit;
   logic        special_hit;
   logic        wdt_run;
   logic [3:0]  mode;
   logic [7:0]  rd_byte;
   logic        rd_hit;

   assign gate_en  = gcon_r[GATE_EN_POS];
   assign gate_pol = gcon_r[GATE_POL_POS];
   assign gate_tog = gcon_r[GATE_TOG_POS];
   assign gate_src = gcon_r[1:0];
   assign mode     = mode_r[3:0];

   // ---- AXI4-Lite write: one at a time, ready drops until B completes
   assign wr_do = aw_full_r && w_full_r && !BVALID;
   assign wr_en = wr_do && w_lane0_r;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         AWREADY   <= 1'b1;
         WREADY    <= 1'b1;
         aw_addr_r <= 8'h00;
         w_data_r  <= 8'h00;
         w_lane0_r <= 1'b0;
         BVALID    <= 1'b0;
         BRESP     <= RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_full_r <= 1'b1;
            AWREADY   <= 1'b0;
            aw_addr_r <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_full_r  <= 1'b1;
            WREADY    <= 1'b0;
            w_data_r  <= WDATA[7:0];
            w_lane0_r <= WSTRB[0];
         end
         if (wr_do) begin
            BVALID <= 1'b1;
            BRESP  <= addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (BVALID && BREADY) begin
            BVALID    <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            AWREADY   <= 1'b1;
            WREADY    <= 1'b1;
         end
      end
   end

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= A_FLAGS);
   endfunction

   // ---- AXI4-Lite read: answer one cycle after the address
   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      unique case (ARADDR)
         A_TIMER_CTRL: rd_byte = ctrl_r;
         A_GATE_CTRL:  rd_byte = gcon_r;
         A_CC_MODE:    rd_byte = {2'h0, mode_r};
         A_CC_LOW:     rd_byte = ccval_r[7:0];
         A_CC_HIGH:    rd_byte = ccval_r[15:8];
         A_COUNT_LOW:  rd_byte = count_r[7:0];
         A_COUNT_HIGH: rd_byte = count_r[15:8];
         A_IRQ_EN:     rd_byte = irqen_r;
         A_FLAGS:      rd_byte = flags_r;
         default:      rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RDATA   <= {24'h00_0000, rd_byte};
         RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
      end
   end

   // ---- control registers
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctrl_r  <= RESET_BYTE;
         mode_r  <= 6'h00;
         ccval_r <= 16'h0000;
         irqen_r <= RESET_BYTE;
      end else begin
         if (wr_en && aw_addr_r == A_TIMER_CTRL) ctrl_r <= w_data_r;
         if (wr_en && aw_addr_r == A_CC_MODE) mode_r <= w_data_r[5:0];
         if (wr_en && aw_addr_r == A_IRQ_EN) irqen_r <= w_data_r;
         if (cap_hit) ccval_r <= count_r;
         else if (wr_en && aw_addr_r == A_CC_LOW) ccval_r[7:0] <= w_data_r;
         else if (wr_en && aw_addr_r == A_CC_HIGH) ccval_r[15:8] <= w_data_r;
      end
   end

   // gate value status bit follows the live gate
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         gcon_r <= RESET_BYTE;
      end else begin
         if (wr_en && aw_addr_r == A_GATE_CTRL) begin
            gcon_r <= (w_data_r & GATE_WR_MASK) | (gcon_r & ~GATE_WR_MASK);
         end else begin
            gcon_r[GATE_VAL_POS] <= gate_active;
         end
      end
   end

   // event flag: hardware set beats a software write in the same cycle
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         flags_r <= RESET_BYTE;
      end else begin
         if (wr_en && aw_addr_r == A_FLAGS) flags_r <= w_data_r;
         if (cap_hit || cmp_hit) flags_r[CC_FLAG_POS] <= 1'b1;
      end
   end

   // ---- internal gate pulses from neighbouring timers
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         t0_prev_valid_r <= 1'b0;
         t0_prev_r  <= 8'h00;
         t2_prev_r  <= 8'h00;
         t0_ovf_r   <= 1'b0;
         t2_match_r <= 1'b0;
      end else begin
         t0_prev_valid_r <= 1'b1;
         t0_prev_r  <= TIMER0_COUNT;
         t2_prev_r  <= TIMER2_COUNT;
         t0_ovf_r   <= t0_prev_valid_r && t0_prev_r == 8'hFF && TIMER0_COUNT == 8'h00;
         t2_match_r <= t0_prev_valid_r && t2_prev_r == TIMER2_PERIOD
                       && TIMER2_COUNT == 8'h00;
      end
   end

   assign wdt_run = (gate_en && gate_src == SRC_WDT) || WATCHDOG_ENABLE_CONFIG;

   wdt_gate_counter u_wdt (
      .clk   (CLK_SYS),
      .srst  (SRST),
      .run   (wdt_run),
      .clear (WATCHDOG_CLEAR),
      .prescaler_assign   (PRESCALER_ASSIGN),
      .rate  (PRESCALER_RATE),
      .ovf   (wdt_ovf)
   );

   // reset and wake never follow from gate use alone
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         WDT_OSC_ON    <= 1'b0;
         WDT_RESET_REQ <= 1'b0;
         WDT_WAKE_REQ  <= 1'b0;
      end else begin
         WDT_OSC_ON    <= wdt_run;
         WDT_RESET_REQ <= wdt_ovf && WATCHDOG_ENABLE_CONFIG && !SLEEP_ACTIVE;
         WDT_WAKE_REQ  <= wdt_ovf && WATCHDOG_ENABLE_CONFIG && SLEEP_ACTIVE;
      end
   end

   // ---- gate selection, polarity and toggle
   always_comb begin
      unique case (gate_src)
         SRC_PIN:      src_raw = GATE_INPUT;
         SRC_T0_OVF:   src_raw = t0_ovf_r;
         SRC_T2_MATCH: src_raw = t2_match_r;
         SRC_WDT:      src_raw = wdt_ovf;
      endcase
   end

   assign src_lvl     = gate_pol ? src_raw : ~src_raw;
   // pulse sources only make sense with toggle; software must pick it
   assign gate_active = gate_tog ? toggle_r : src_lvl;

   always_ff @(posedge CLK_SYS) begin
      if (SRST || !gate_en || !gate_tog) begin
         toggle_r   <= 1'b0;
         src_prev_r <= 1'b0;
      end else begin
         src_prev_r <= src_lvl;
         if (src_lvl && !src_prev_r) toggle_r <= ~toggle_r;
      end
   end

   // ---- the 16-bit timer
   assign inc_en = ctrl_r[TIMER_ON_POS] && TIMER_TICK && (!gate_en || gate_active);
   assign cnt_wr = wr_en && (aw_addr_r == A_COUNT_LOW || aw_addr_r == A_COUNT_HIGH);

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         count_r <= 16'h0000;
      end else if (wr_en && aw_addr_r == A_COUNT_LOW) begin
         count_r[7:0] <= w_data_r;
      end else if (wr_en && aw_addr_r == A_COUNT_HIGH) begin
         count_r[15:8] <= w_data_r;
      end else if (special_hit) begin
         count_r <= 16'h0000;
      end else if (inc_en) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // ---- capture and compare
   cc_capture_edge u_cap (
      .clk  (CLK_SYS),
      .srst (SRST),
      .mode (mode),
      .pin  (CC_INPUT_PIN),
      .evt  (cap_evt)
   );

   assign cap_hit     = cap_evt && is_capture(mode);
   // edge of equality so a held timer does not re-fire each cycle
   assign cmp_hit     = is_compare(mode) && count_r == ccval_r && !match_prev_r;
   assign special_hit = cmp_hit && mode == M_CMP_SPECIAL;

   always_ff @(posedge CLK_SYS) begin
      if (SRST || mode == M_OFF) begin
         match_prev_r  <= 1'b0;
         CC_OUTPUT_PIN <= 1'b0;
         ADC_START     <= 1'b0;
      end else begin
         match_prev_r <= is_compare(mode) && count_r == ccval_r;
         ADC_START    <= special_hit && ADC_ENABLE;
         if (cmp_hit) begin
            unique case (mode)
               M_CMP_TOGGLE: CC_OUTPUT_PIN <= ~CC_OUTPUT_PIN;
               M_CMP_SET:    CC_OUTPUT_PIN <= 1'b1;
               M_CMP_CLR:    CC_OUTPUT_PIN <= 1'b0;
               default:      CC_OUTPUT_PIN <= CC_OUTPUT_PIN;
            endcase
         end
      end
   end

   // ---- checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   a_free_count: assert property (
      ctrl_r[TIMER_ON_POS] && !gate_en && TIMER_TICK && !cnt_wr && !special_hit
      |=> count_r == $past(count_r) + 16'h0001) else $error("free count missed");
   a_gate_hold: assert property (
      gate_en && !gate_active && !cnt_wr && !special_hit
      |=> $stable(count_r)) else $error("count moved with gate shut");
   a_pol_low: assert property (
      gate_en && !gate_tog && !gate_pol && gate_src == SRC_PIN
      |-> gate_active == !GATE_INPUT) else $error("low polarity wrong");
   a_src_t2: assert property (
      !gate_tog && gate_src == SRC_T2_MATCH
      |-> gate_active == (gate_pol ? t2_match_r : !t2_match_r))
      else $error("source select wrong");
   a_t0_pulse: assert property (
      t0_prev_valid_r && t0_prev_r == 8'hFF && TIMER0_COUNT == 8'h00
      |=> t0_ovf_r ##1 !t0_ovf_r) else $error("timer0 pulse missing");
   a_t2_pulse: assert property (
      t0_prev_valid_r && t2_prev_r == TIMER2_PERIOD && TIMER2_COUNT == 8'h00
      |=> t2_match_r) else $error("timer2 pulse missing");
   a_wdt_power: assert property (
      gate_en && gate_src == SRC_WDT |=> WDT_OSC_ON) else $error("watchdog not on");
   a_wdt_no_reset: assert property (
      !$past(WATCHDOG_ENABLE_CONFIG) |-> !WDT_RESET_REQ && !WDT_WAKE_REQ)
      else $error("watchdog reset without enable");
   a_mode_off: assert property (
      mode == M_OFF |=> !CC_OUTPUT_PIN && !ADC_START) else $error("off mode active");
   a_cmp_toggle: assert property (
      cmp_hit && mode == M_CMP_TOGGLE
      |=> CC_OUTPUT_PIN != $past(CC_OUTPUT_PIN) && flags_r[CC_FLAG_POS])
      else $error("toggle on match failed");
   a_cmp_set: assert property (
      cmp_hit && mode == M_CMP_SET |=> CC_OUTPUT_PIN) else $error("set on match failed");
   a_cmp_soft: assert property (
      cmp_hit && mode == M_CMP_SOFT |=> $stable(CC_OUTPUT_PIN) && flags_r[CC_FLAG_POS])
      else $error("soft match touched pin");
   a_special: assert property (
      special_hit && !cnt_wr |=> count_r == 16'h0000 && ADC_START == $past(ADC_ENABLE))
      else $error("special event failed");
   a_reserved: assert property (
      mode == M_RSV1 || mode == M_RSV3 |-> !cmp_hit && !cap_hit)
      else $error("reserved mode acted");
   a_cap_copy: assert property (
      cap_hit |=> ccval_r == $past(count_r) && flags_r[CC_FLAG_POS])
      else $error("capture copy failed");

   c_capture: cover property (cap_hit);
   c_compare: cover property (cmp_hit && mode == M_CMP_TOGGLE);
   c_gated_inc: cover property (gate_en && inc_en);
   c_wdt_gate: cover property (gate_src == SRC_WDT && wdt_ovf);
endmodule
`default_nettype wire

/* File: tb/far_side_model.sv */
// Purpose: timer0, timer2 and timer clock seen by the gated timer
// Assumes: timer clock edge every second system clock
// Notes:   timer2 period fixed at 7
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input  wire logic       clk,      // system clock
   input  wire logic       srst,     // sync reset
   output logic            tick,     // timer clock edge
   output logic [7:0]      t0_count, // timer0 count
   output logic [7:0]      t2_count, // timer2 count
   output logic [7:0]      t2_period // timer2 period
);
   assign t2_period = 8'h07;
   always_ff @(posedge clk) begin
      if (srst) begin
         tick <= 1'b0;
         t0_count <= 8'h00;
         t2_count <= 8'h00;
      end else begin
         tick <= ~tick;
         t0_count <= t0_count + 8'h01;
         t2_count <= (t2_count == t2_period) ? 8'h00 : t2_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: register-level test of the gated timer and mode unit
// Assumes: far side from far_side_model
// Notes:   every wait is bounded
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,v) begin tests_run++; if ((v)!==(e)) begin n_fail++; \
 $display("BAD %s exp %h got %h",n,e,v); end end
module tb import gtc_pkg::*;;
   logic CLK_SYS, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
   logic RVALID, RREADY, TIMER_TICK, GATE_INPUT, CC_INPUT_PIN, CC_OUTPUT_PIN, WDT_OSC_ON;
   logic ADC_ENABLE, ADC_START, WDT_RESET_REQ, WDT_WAKE_REQ, seen_adc, seen_wdt;
   logic [7:0] AWADDR, ARADDR, TIMER0_COUNT, TIMER2_COUNT, TIMER2_PERIOD, d, e;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, r;
   int n_fail, tests_run, i, k;
   logic [3:0] md [5] = '{M_CMP_SET, M_CMP_CLR, M_CMP_TOGGLE, M_CMP_SOFT, M_RSV1};
   logic [4:0] pin_exp = 5'b11101;
   timer_gate_ccp timer_gate_ccp_inst (.CLK_SYS, .SRST, .AWADDR, .AWVALID, .AWREADY, .WDATA,
      .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
      .RRESP, .RVALID, .RREADY, .TIMER_TICK, .GATE_INPUT, .TIMER0_COUNT, .TIMER2_COUNT,
      .TIMER2_PERIOD, .PRESCALER_ASSIGN(1'b0), .PRESCALER_RATE(3'h0),
      .WATCHDOG_ENABLE_CONFIG(1'b0), .WATCHDOG_CLEAR(1'b0), .SLEEP_ACTIVE(1'b0), .CC_INPUT_PIN,
      .ADC_ENABLE, .CC_OUTPUT_PIN, .ADC_START, .WDT_OSC_ON, .WDT_RESET_REQ,
      .WDT_WAKE_REQ);
   far_side_model far_side_model_inst (.clk(CLK_SYS), .srst(SRST), .tick(TIMER_TICK),
      .t0_count(TIMER0_COUNT), .t2_count(TIMER2_COUNT), .t2_period(TIMER2_PERIOD));
   // sticky: one-cycle pulses would slip past a single sample
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         seen_adc <= 1'b0;
         seen_wdt <= 1'b0;
      end else begin
         if (ADC_START) seen_adc <= 1'b1;
         if (WDT_RESET_REQ || WDT_WAKE_REQ) seen_wdt <= 1'b1;
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang(input int j);
      if (j >= 60) begin
         n_fail++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int j;
      @(posedge CLK_SYS);
      AWADDR <= a; WDATA <= {24'h0, v}; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
      for (j = 0; j < 60; j++) begin
         @(posedge CLK_SYS);
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
         if (BVALID && BREADY) break;
      end
      hang(j);
      r = BRESP; BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int j;
      @(posedge CLK_SYS);
      ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
      for (j = 0; j < 60 && !(ARVALID && ARREADY); j++) @(posedge CLK_SYS);
      ARVALID <= 1'b0;
      for (j = j; j < 60 && !RVALID; j++) @(posedge CLK_SYS);
      hang(j);
      d = RDATA[7:0]; r = RRESP; RREADY <= 1'b0;
   endtask
   initial begin
      CLK_SYS = 0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, CC_INPUT_PIN, ADC_ENABLE} = '0;
      {AWADDR, ARADDR, WDATA} = '0; WSTRB = 4'hF; GATE_INPUT = 1'b1; SRST = 1'b1;
      repeat (20) @(posedge CLK_SYS);
      SRST <= 1'b0;
      rd(A_CC_MODE); `CHK("mode reset", 8'h00, d)
      wr(A_CC_MODE, 8'hFF); rd(A_CC_MODE); `CHK("mode top bits", 8'h3F, d)
      rd(8'h24); `CHK("unmapped", RESP_SLVERR, r)
      wr(8'h24, 8'h00); `CHK("unmapped write", RESP_SLVERR, r)
      wr(A_TIMER_CTRL, 8'h01); rd(A_COUNT_LOW); e = d; rd(A_COUNT_LOW);
      `CHK("free run", 1'b1, d !== e)
      wr(A_GATE_CTRL, 8'h80); rd(A_COUNT_LOW); e = d; rd(A_COUNT_LOW);
      `CHK("gate holds", e, d)
      wr(A_GATE_CTRL, 8'hC0); rd(A_COUNT_LOW); e = d; rd(A_COUNT_LOW);
      `CHK("gate counts", 1'b1, d !== e)
      wr(A_GATE_CTRL, 8'h82); rd(A_COUNT_LOW); e = d; repeat (8) @(posedge CLK_SYS);
      rd(A_COUNT_LOW); `CHK("timer2 gate", 1'b1, d !== e)
      wr(A_GATE_CTRL, 8'hE3); repeat (80) @(posedge CLK_SYS);
      `CHK("wdt osc", 1'b1, WDT_OSC_ON)
      `CHK("wdt no reset", 1'b0, seen_wdt)
      wr(A_GATE_CTRL, 8'h00); wr(A_CC_MODE, {4'h0, M_OFF}); wr(A_CC_LOW, 8'h20);
      for (k = 0; k < 5; k++) begin
         wr(A_FLAGS, 8'h00); wr(A_COUNT_LOW, 8'h00); wr(A_CC_MODE, {4'h0, md[k]});
         repeat (150) @(posedge CLK_SYS);
         `CHK("compare pin", pin_exp[k], CC_OUTPUT_PIN)
         rd(A_FLAGS); `CHK("compare flag", (k < 4) ? 8'h04 : 8'h00, d)
      end
      ADC_ENABLE <= 1'b1; wr(A_COUNT_LOW, 8'h00); wr(A_CC_MODE, {4'h0, M_CMP_SPECIAL});
      repeat (150) @(posedge CLK_SYS);
      `CHK("special adc", 1'b1, seen_adc)
      rd(A_COUNT_LOW); `CHK("special clear", 1'b1, d < 8'h20)
      wr(A_TIMER_CTRL, 8'h00); wr(A_COUNT_LOW, 8'h5A); wr(A_CC_MODE, {4'h0, M_CAP_RISE});
      repeat (3) @(posedge CLK_SYS);
      CC_INPUT_PIN <= 1'b1;
      rd(A_CC_LOW); `CHK("capture rise", 8'h5A, d)
      wr(A_COUNT_LOW, 8'h3C); wr(A_CC_MODE, {4'h0, M_CAP_FALL});
      repeat (3) @(posedge CLK_SYS);
      CC_INPUT_PIN <= 1'b0;
      rd(A_CC_LOW); `CHK("capture fall", 8'h3C, d)
      wr(A_CC_MODE, {4'h0, M_CAP_RISE4});
      for (k = 0; k < 4; k++) begin
         wr(A_COUNT_LOW, 8'h40 + k[7:0]);
         CC_INPUT_PIN <= 1'b1;
         repeat (2) @(posedge CLK_SYS);
         CC_INPUT_PIN <= 1'b0;
         rd(A_CC_LOW); `CHK("capture 4th", (k == 3) ? 8'h43 : 8'h3C, d)
      end
      close_out();
   end
endmodule
`default_nettype wire
